// ==== rtl/bcl_bus_engine.sv ====
// Local design decisions: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module bcl_bus_engine
    import bcl_pkg::*;
(
    input  wire logic         core_clk_in,
    input  wire logic         srst_in,
    input  wire logic         req_valid_in,
    input  wire bcl_req_type  req_in,
    output logic              req_ready_out,
    input  wire logic         queue_full_in,
    input  wire logic         queue_purge_in,
    input  wire logic [23:0]  fetch_addr_in,
    output logic              resp_valid_out,
    output bcl_resp_type      resp_out,
    input  wire logic         rdy_in,
    input  wire logic         slave_done_in,
    input  wire logic [15:0]  muxed_addr_data_bus_in,
    output logic [15:0]       muxed_addr_data_bus_out,
    output logic              muxed_addr_data_bus_oe_out,
    output logic [7:0]        upper_address_lines_out,
    output logic [3:0]        bus_status_lines_out,
    output logic              high_byte_enable_n_out,
    output logic              address_bit_zero_out,
    output logic              addr_strobe_n_out,
    output logic              data_strobe_n_out,
    output logic              read_dir_out
);
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_TS   = 6'b000010,
        S_T1   = 6'b000100,
        S_T2   = 6'b001000,
        S_T3   = 6'b010000,
        S_T4   = 6'b100000
    } bcl_state_type;

    bcl_state_type st_q, st_d;
    logic [3:0]    status_q, status_d;
    logic [23:0]   addr_q, addr_d;
    logic [2:0]    left_q, left_d;
    logic [1:0]    off_q, off_d;
    logic          wr_q, wr_d;
    logic [31:0]   wbuf_q, wbuf_d;
    logic [31:0]   rbuf_q, rbuf_d;
    logic          more_q, more_d;
    logic          purge_q, purge_d;
    logic [2:0]    rdy_s_q, rdy_s_d;
    logic          rdy_q, rdy_d;
    logic [2:0]    done_s_q, done_s_d;
    logic          slave_done_q, slave_done_d;
    logic          resp_valid_q, resp_valid_d;
    bcl_resp_type  resp_q, resp_d;
    logic [15:0]   ad_q, ad_d;
    logic          oe_q, oe_d;
    logic [7:0]    upper_q, upper_d;
    logic          hbe_n_q, hbe_n_d;
    logic          a0_q, a0_d;
    logic          ads_n_q, ads_n_d;
    logic          ds_n_q, ds_n_d;
    logic          dir_q, dir_d;

    bcl_piece_type piece;
    logic          last_t3;
    logic          can_take;
    logic          slave_blk;
    logic          take_req;
    logic          take_fetch;
    logic [31:0]   rd_all;
    logic          enter_t1;

    bcl_lane_split u_lane (
        .addr_in   (addr_q),
        .left_in   (left_q),
        .off_in    (off_q),
        .wbuf_in   (wbuf_q),
        .piece_out (piece)
    );

    assign last_t3  = (st_q == S_T3) && rdy_q;
    assign can_take = (st_q == S_IDLE) || (last_t3 && (left_q == {1'b0, piece.nbytes}));
    assign slave_blk  = req_valid_in && (req_in.kind == ST_SLV_STAT) && !slave_done_q;
    assign take_req   = can_take && req_valid_in && !slave_blk;
    assign take_fetch = can_take && !take_req && !queue_full_in;
    assign req_ready_out = take_req;

    // low lanes carry even bytes, high lanes odd
    always_comb begin
        rd_all = rbuf_q;
        // writes keep the buffer zero; the lanes then carry only our own data
        if (!wr_q) begin
            case ({piece.hbe_n, piece.a0})
                LANE_ODD_BYTE:  rd_all = put_byte(rbuf_q, off_q, muxed_addr_data_bus_in[15:8]);
                LANE_EVEN_BYTE: rd_all = put_byte(rbuf_q, off_q, muxed_addr_data_bus_in[7:0]);
                default: rd_all = put_byte(put_byte(rbuf_q, off_q, muxed_addr_data_bus_in[7:0]),
                                           2'(off_q + 2'h1), muxed_addr_data_bus_in[15:8]);
            endcase
        end
    end

    always_comb begin
        st_d = st_q;          status_d = status_q;  addr_d = addr_q;   left_d = left_q;
        off_d = off_q;        wr_d = wr_q;          wbuf_d = wbuf_q;   rbuf_d = rbuf_q;
        more_d = more_q;      purge_d = purge_q;    resp_d = resp_q;   resp_valid_d = 1'b0;
        ad_d = ad_q;          oe_d = oe_q;          upper_d = upper_q; hbe_n_d = hbe_n_q;
        a0_d = a0_q;          ads_n_d = ads_n_q;    ds_n_d = ds_n_q;   dir_d = dir_q;
        enter_t1 = 1'b0;
        // pins pass three flops; a change counts once the last two agree
        rdy_s_d  = {rdy_s_q[1:0], rdy_in};
        rdy_d    = (rdy_s_q[1] == rdy_s_q[2]) ? rdy_s_q[2] : rdy_q;
        done_s_d = {done_s_q[1:0], slave_done_in};
        slave_done_d = (done_s_q[1] == done_s_q[2]) ? done_s_q[2] : slave_done_q;

        case (st_q)
            S_IDLE: begin
                // status leads the cycle by one clock
                if (take_req || take_fetch) begin
                    st_d = S_TS;
                end else begin
                    status_d = slave_blk ? ST_SLV_WAIT : ST_IDLE;
                end
            end
            S_TS: begin
                st_d = S_T1;
                enter_t1 = 1'b1;
            end
            S_T1: begin
                st_d = S_T2;
                ads_n_d = 1'b1;
                ds_n_d = 1'b0;
                ad_d = wr_q ? piece.wdata : ad_q;
                oe_d = wr_q;
            end
            S_T2: begin
                st_d = S_T3;
            end
            S_T3: begin
                if (rdy_q) begin
                    st_d = S_T4;
                    ds_n_d = 1'b1;
                    rbuf_d = rd_all;
                    addr_d = addr_q + 24'(piece.nbytes);
                    off_d = 2'(off_q + piece.nbytes);
                    left_d = left_q - {1'b0, piece.nbytes};
                    more_d = (left_q != {1'b0, piece.nbytes});
                    if (!more_d) begin
                        resp_valid_d = 1'b1;
                        resp_d.kind = status_q;
                        resp_d.rdata = rd_all;
                        // trap and flags from the slave word
                        resp_d.trap = (status_q == ST_SLV_STAT) && rd_all[SW_TRAP_BIT];
                        resp_d.psr_nzlf = {rd_all[SW_N_BIT], rd_all[SW_Z_BIT],
                                           rd_all[SW_L_BIT], rd_all[SW_F_BIT]};
                        more_d = take_req || take_fetch;
                        if (!more_d) begin
                            status_d = slave_blk ? ST_SLV_WAIT : ST_IDLE;
                        end
                    end
                end
            end
            S_T4: begin
                if (more_q) begin
                    st_d = S_T1;
                    enter_t1 = 1'b1;
                end else begin
                    st_d = S_IDLE;
                    oe_d = 1'b0;
                end
            end
            default: begin
                st_d = S_IDLE;
            end
        endcase

        // status taken from the request kind, or from the purge flag for a fetch
        if (take_req) begin
            status_d = req_in.kind;
            wr_d = req_in.write;
            addr_d = req_in.addr;
            // any size from any byte address; size zero moves one byte
            left_d = (req_in.size == 3'h0) ? 3'h1 : req_in.size;
            wbuf_d = req_in.wdata;
        end else if (take_fetch) begin
            status_d = purge_q ? ST_FETCH_NSEQ : ST_FETCH_SEQ;
            wr_d = 1'b0;
            addr_d = fetch_addr_in;
            left_d = FETCH_BYTES;
            wbuf_d = '0;
        end
        if (take_req || take_fetch) begin
            off_d = 2'h0;
            rbuf_d = '0;
        end
        // purge set wins over the clearing fetch
        if (take_fetch) begin
            purge_d = 1'b0;
        end
        if (queue_purge_in) begin
            purge_d = 1'b1;
        end

        if (enter_t1) begin
            // full 24-bit byte address on the bus
            ad_d = addr_q[15:0];
            upper_d = addr_q[23:16];
            oe_d = 1'b1;
            ads_n_d = 1'b0;
            dir_d = !wr_q;
            // lane category on the enable and bit zero
            hbe_n_d = piece.hbe_n;
            a0_d = piece.a0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            st_q <= S_IDLE;        status_q <= STATUS_RST; addr_q <= '0;  left_q <= '0;
            off_q <= '0;           wr_q <= 1'b0;           wbuf_q <= '0;  rbuf_q <= '0;
            more_q <= 1'b0;        purge_q <= 1'b1;        rdy_s_q <= SYNC_RST;
            rdy_q <= 1'b0;         done_s_q <= SYNC_RST;   slave_done_q <= 1'b0;
            resp_valid_q <= 1'b0;  resp_q <= '0;           ad_q <= '0;    oe_q <= 1'b0;
            upper_q <= '0;         hbe_n_q <= STROBE_N_RST; a0_q <= 1'b0;
            ads_n_q <= STROBE_N_RST; ds_n_q <= STROBE_N_RST; dir_q <= 1'b0;
        end else begin
            st_q <= st_d;          status_q <= status_d;   addr_q <= addr_d; left_q <= left_d;
            off_q <= off_d;        wr_q <= wr_d;           wbuf_q <= wbuf_d; rbuf_q <= rbuf_d;
            more_q <= more_d;      purge_q <= purge_d;     rdy_s_q <= rdy_s_d;
            rdy_q <= rdy_d;        done_s_q <= done_s_d;   slave_done_q <= slave_done_d;
            resp_valid_q <= resp_valid_d; resp_q <= resp_d; ad_q <= ad_d; oe_q <= oe_d;
            upper_q <= upper_d;    hbe_n_q <= hbe_n_d;     a0_q <= a0_d;
            ads_n_q <= ads_n_d;    ds_n_q <= ds_n_d;       dir_q <= dir_d;
        end
    end

    assign resp_valid_out             = resp_valid_q;
    assign resp_out                   = resp_q;
    assign muxed_addr_data_bus_out    = ad_q;
    assign muxed_addr_data_bus_oe_out = oe_q;
    assign upper_address_lines_out    = upper_q;
    assign bus_status_lines_out       = status_q;
    assign high_byte_enable_n_out     = hbe_n_q;
    assign address_bit_zero_out       = a0_q;
    assign addr_strobe_n_out          = ads_n_q;
    assign data_strobe_n_out          = ds_n_q;
    assign read_dir_out               = dir_q;

    // checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    a_lane_legal: assert property (!ads_n_q |-> {hbe_n_q, a0_q} != 2'h3)
        else $error("odd address with high byte disabled");
    a_status_lead: assert property (st_q == S_T1 |-> status_q == $past(status_q))
        else $error("status not stable one clock before first state");
    a_status_hold: assert property ((st_q == S_T2) || (st_q == S_T3) |-> $stable(status_q))
        else $error("status changed inside a bus cycle");
    a_addr_full: assert property (st_q == S_T1 |-> {upper_q, ad_q} == addr_q)
        else $error("bus does not show the full byte address");
    a_rmw_read: assert property (!ads_n_q && status_q == ST_RMW |-> dir_q)
        else $error("modify-write status on a non-read cycle");
    a_back_to_back: assert property ((st_q == S_T4) && more_q |=> st_q == S_T1)
        else $error("idle state between cycles of an operand");
    a_odd_split: assert property (!ads_n_q && a0_q && (left_q > 3'h1)
        |=> ##[2:40] !ads_n_q && !a0_q)
        else $error("odd cycle not followed by next even cycle");
    a_nseq_fetch: assert property (purge_q && st_q == S_IDLE && !req_valid_in
        && !queue_full_in |=> status_q == ST_FETCH_NSEQ)
        else $error("purged fetch not marked nonsequential");
    a_seq_fetch: assert property (!purge_q && st_q == S_IDLE && !req_valid_in
        && !queue_full_in |=> status_q == ST_FETCH_SEQ ##1 st_q == S_T1)
        else $error("idle bus with free queue did not fetch");
    a_slave_wait: assert property (st_q == S_TS && status_q == ST_SLV_STAT
        |-> $past(slave_done_q))
        else $error("slave status read before done");
    a_trap_word: assert property (resp_valid_q && resp_q.kind == ST_SLV_STAT
        |-> resp_q.trap == resp_q.rdata[SW_TRAP_BIT])
        else $error("trap does not follow slave word");
    a_id_write: assert property (st_q == S_T2 && status_q == ST_SLV_ID && wr_q
        |-> oe_q && ad_q == piece.wdata)
        else $error("identifier byte not driven");

    c_odd_word: cover property (!ads_n_q && a0_q ##4 !ads_n_q);
    c_wait_state: cover property ((st_q == S_T3) [*2]);
    c_slave_stat: cover property (resp_valid_q && resp_q.kind == ST_SLV_STAT);
endmodule // bcl_bus_engine
`default_nettype wire

// ==== rtl/bcl_lane_split.sv ====
`timescale 1ns/10ps
`default_nettype none
// picks the next bus cycle of an operand from its address and the bytes left
module bcl_lane_split
    import bcl_pkg::*;
(
    input  wire logic [23:0]   addr_in,
    input  wire logic [2:0]    left_in,
    input  wire logic [1:0]    off_in,
    input  wire logic [31:0]   wbuf_in,
    output bcl_piece_type      piece_out
);
    logic [7:0] b0;
    logic [7:0] b1;

    assign b0 = get_byte(wbuf_in, off_in);
    assign b1 = get_byte(wbuf_in, 2'(off_in + 2'h1));

    always_comb begin
        piece_out = '0;
        if (addr_in[0]) begin
            {piece_out.hbe_n, piece_out.a0} = LANE_ODD_BYTE;
            piece_out.nbytes = 2'h1;
            piece_out.wdata  = {b0, 8'h00};
        end else if (left_in >= 3'h2) begin
            {piece_out.hbe_n, piece_out.a0} = LANE_EVEN_WORD;
            piece_out.nbytes = 2'h2;
            piece_out.wdata  = {b1, b0};
        end else begin
            {piece_out.hbe_n, piece_out.a0} = LANE_EVEN_BYTE;
            piece_out.nbytes = 2'h1;
            piece_out.wdata  = {8'h00, b0};
        end
    end
endmodule // bcl_lane_split
`default_nettype wire

// ==== rtl/bcl_pkg.sv ====
package bcl_pkg;

    // bus status codes, line zero is the least significant bit
    localparam logic [3:0] ST_IDLE       = 4'h0;
    localparam logic [3:0] ST_SLV_WAIT   = 4'h3;
    localparam logic [3:0] ST_FETCH_SEQ  = 4'h8;
    localparam logic [3:0] ST_FETCH_NSEQ = 4'h9;
    localparam logic [3:0] ST_DATA       = 4'ha;
    localparam logic [3:0] ST_RMW        = 4'hb;
    localparam logic [3:0] ST_EA         = 4'hc;
    localparam logic [3:0] ST_SLV_OP     = 4'hd;
    localparam logic [3:0] ST_SLV_STAT   = 4'he;
    localparam logic [3:0] ST_SLV_ID     = 4'hf;

    // byte-lane categories as {high_byte_enable_n, address_bit_zero}
    localparam logic [1:0] LANE_EVEN_BYTE = 2'h2;
    localparam logic [1:0] LANE_ODD_BYTE  = 2'h1;
    localparam logic [1:0] LANE_EVEN_WORD = 2'h0;

    // slave status word fields
    localparam int SW_TRAP_BIT = 0;
    localparam int SW_F_BIT    = 5;
    localparam int SW_Z_BIT    = 6;
    localparam int SW_N_BIT    = 7;
    localparam int SW_L_BIT    = 2;

    localparam logic [2:0] FETCH_BYTES   = 3'h2;
    localparam logic [3:0] STATUS_RST    = ST_IDLE;
    localparam logic       STROBE_N_RST  = 1'b1;
    localparam logic [2:0] SYNC_RST      = 3'h0;

    typedef struct packed {
        logic [3:0]  kind;
        logic        write;
        logic [23:0] addr;
        logic [2:0]  size;
        logic [31:0] wdata;
    } bcl_req_type;

    typedef struct packed {
        logic [3:0]  kind;
        logic [31:0] rdata;
        logic        trap;
        logic [3:0]  psr_nzlf;
    } bcl_resp_type;

    typedef struct packed {
        logic        hbe_n;
        logic        a0;
        logic [1:0]  nbytes;
        logic [15:0] wdata;
    } bcl_piece_type;

    function automatic logic [7:0] get_byte(input logic [31:0] w, input logic [1:0] off);
        get_byte = w[{off, 3'h0} +: 8];
    endfunction

    function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] off,
                                             input logic [7:0] b);
        logic [31:0] r;
        r = w;
        r[{off, 3'h0} +: 8] = b;
        put_byte = r;
    endfunction

endpackage

// ==== verification/bcl_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// one byte array standing for memory and the one claiming slave
module bcl_mem_model
    import bcl_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        slow_in,
    input  wire logic        done_in,
    input  wire logic [15:0] bus_in,
    input  wire logic        bus_oe_in,
    input  wire logic        ads_n_in,
    input  wire logic        ds_n_in,
    input  wire logic        hbe_n_in,
    input  wire logic        a0_in,
    input  wire logic        read_in,
    output logic [15:0]      bus_out,
    output logic             rdy_out,
    output logic             done_out
);
    logic [7:0] mem [0:255];
    logic [7:0] wa;
    logic       lo_en;
    logic       hi_en;
    logic [2:0] cnt;

    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
        bus_out = 16'h0;
        cnt = 3'h0;
        wa = 8'h0;
        lo_en = 1'b0;
        hi_en = 1'b0;
    end

    // only this slave answers after the broadcast
    assign done_out = done_in;
    // slow mode holds ready low half of the time to force wait states
    assign rdy_out  = !slow_in || cnt[2];

    always @(posedge core_clk_in) begin
        cnt <= cnt + 3'h1;
        if (!ads_n_in) begin
            wa    <= {bus_in[7:1], 1'b0};
            lo_en <= !a0_in;
            hi_en <= !hbe_n_in;
        end
        // no region here is write-protected, so no rmw read is ever aborted
        // status word supplied by the addressed slave
        if (!ds_n_in && read_in) begin
            bus_out <= {hi_en ? mem[wa + 8'h1] : ~bus_out[15:8], lo_en ? mem[wa] : ~bus_out[7:0]};
        end else begin
            // released lanes never keep the last value
            bus_out <= ~bus_out;
        end
        if (!ds_n_in && !read_in && bus_oe_in) begin
            if (lo_en) mem[wa] <= bus_in[7:0];
            if (hi_en) mem[wa + 8'h1] <= bus_in[15:8];
        end
    end
endmodule // bcl_mem_model
`default_nettype wire

// ==== verification/cpu_bus_status_byte_lanes_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_status_byte_lanes_tb;
    import bcl_pkg::*;
    typedef struct packed {
        logic        first;
        logic [3:0]  kind;
        logic [1:0]  lane;
        logic [23:0] addr;
    } bcl_cyc_type;

    logic core_clk_in = 1'b0, srst_in = 1'b1, req_valid_in = 1'b0;
    logic queue_full_in = 1'b1, queue_purge_in = 1'b0, slow = 1'b0, done = 1'b0;
    logic req_ready_out, resp_valid_out, rdy_in, slave_done_in, ad_oe, ads_n, ds_n, dir;
    logic hbe_n, a0;
    logic [3:0]   st;
    logic [3:0]   prev_st = 4'h0;
    logic [7:0]   upper;
    logic [15:0]  ad_in, ad_out;
    logic [23:0]  fetch_addr_in = 24'h000040;
    bcl_req_type  req_in = '0;
    bcl_resp_type resp_out;
    logic [7:0]   sh [0:255];
    bcl_resp_type resp_q [$];
    bcl_cyc_type  cyc_q [$];
    int n_mismatch = 0, total_checks = 0, cyc = 0, last_ads = 0, last_slow = 0;
    logic [3:0]   kinds [0:4] = '{ST_DATA, ST_RMW, ST_EA, ST_SLV_OP, ST_SLV_ID};

    bcl_bus_engine DUT (.core_clk_in(core_clk_in), .srst_in(srst_in),
        .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
        .queue_full_in(queue_full_in), .queue_purge_in(queue_purge_in),
        .fetch_addr_in(fetch_addr_in), .resp_valid_out(resp_valid_out), .resp_out(resp_out),
        .rdy_in(rdy_in), .slave_done_in(slave_done_in), .muxed_addr_data_bus_in(ad_in),
        .muxed_addr_data_bus_out(ad_out), .muxed_addr_data_bus_oe_out(ad_oe),
        .upper_address_lines_out(upper), .bus_status_lines_out(st),
        .high_byte_enable_n_out(hbe_n), .address_bit_zero_out(a0),
        .addr_strobe_n_out(ads_n), .data_strobe_n_out(ds_n), .read_dir_out(dir));
    bcl_mem_model far_side (.core_clk_in(core_clk_in), .slow_in(slow), .done_in(done),
        .bus_in(ad_out), .bus_oe_in(ad_oe), .ads_n_in(ads_n), .ds_n_in(ds_n),
        .hbe_n_in(hbe_n), .a0_in(a0), .read_in(dir), .bus_out(ad_in), .rdy_out(rdy_in),
        .done_out(slave_done_in));

    initial begin
        forever #10 core_clk_in = ~core_clk_in;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // notes expected lanes and answer, then presents the request
    task automatic issue(input logic [3:0] k, input logic w, input logic [23:0] a,
                         input logic [2:0] sz, input logic [31:0] wd);
        bcl_resp_type e;
        bcl_cyc_type  c;
        logic [23:0]  p;
        logic [2:0]   left;
        e = '0;
        e.kind = k;
        for (int i = 0; i < sz; i++) begin
            if (w) sh[a[7:0] + 8'(i)] = wd[8*i +: 8];
            else e.rdata[8*i +: 8] = sh[a[7:0] + 8'(i)];
        end
        e.trap = (k == ST_SLV_STAT) && e.rdata[0];
        e.psr_nzlf = {e.rdata[7], e.rdata[6], e.rdata[2], e.rdata[5]};
        p = a;
        left = sz;
        while (left != 3'h0) begin
            c.lane = p[0] ? LANE_ODD_BYTE : (left >= 3'h2) ? LANE_EVEN_WORD : LANE_EVEN_BYTE;
            c.first = (p == a);
            c.kind = k;
            c.addr = p;
            cyc_q.push_back(c);
            p = p + ((c.lane == LANE_EVEN_WORD) ? 24'h2 : 24'h1);
            left = left - ((c.lane == LANE_EVEN_WORD) ? 3'h2 : 3'h1);
        end
        resp_q.push_back(e);
        req_in <= '{k, w, a, sz, wd};
        req_valid_in <= 1'b1;
    endtask

    task automatic take();
        int i;
        i = 0;
        do begin
            @(negedge core_clk_in);
            i++;
        end while (!req_ready_out && i < 99);
        if (req_ready_out !== 1'b1) begin
            n_mismatch++;
            summarize();
        end
        @(posedge core_clk_in);
    endtask

    task automatic op(input logic [3:0] k, input logic w, input logic [23:0] a,
                      input logic [2:0] sz, input logic [31:0] wd);
        issue(k, w, a, sz, wd);
        take();
    endtask

    task automatic idle();
        int i;
        req_valid_in <= 1'b0;
        for (i = 0; i < 300 && (resp_q.size() != 0 || cyc_q.size() != 0); i++)
            @(posedge core_clk_in);
        if (i == 300) begin
            n_mismatch++;
            summarize();
        end
        @(posedge core_clk_in);
    endtask

    task automatic wait_ads();
        int i;
        i = 0;
        do begin
            @(negedge core_clk_in);
            i++;
        end while (ads_n && i < 40);
        if (ads_n !== 1'b0) begin
            n_mismatch++;
            summarize();
        end
    endtask

    // response and bus-cycle watchers pop the oldest notes
    always @(negedge core_clk_in) begin
        bcl_cyc_type  c;
        bcl_resp_type e;
        cyc++;
        // ready is synchronised, so wait states trail a slow phase by a few cycles
        if (slow) last_slow = cyc;
        if (!srst_in && !ads_n) begin
            check(prev_st, st);
            if (st == ST_FETCH_SEQ || st == ST_FETCH_NSEQ) begin
                check({hbe_n, a0, upper, ad_out}, {LANE_EVEN_WORD, fetch_addr_in});
            end else if (cyc_q.size() == 0) begin
                check(st, 4'h0);
            end else begin
                c = cyc_q.pop_front();
                check({ad_oe, st, hbe_n, a0, upper, ad_out}, {1'b1, c.kind, c.lane, c.addr});
                if (!c.first && (last_ads - last_slow > 5)) check(cyc - last_ads, 4);
            end
            last_ads = cyc;
        end
        prev_st = st;
        if (!srst_in && resp_valid_out && st !== 4'hx && resp_out.kind != ST_FETCH_SEQ
            && resp_out.kind != ST_FETCH_NSEQ) begin
            if (resp_q.size() == 0) begin
                check(resp_out, '0);
            end else begin
                e = resp_q.pop_front();
                check({resp_out.kind, resp_out.rdata, resp_out.trap},
                      {e.kind, e.rdata, e.trap});
                if (e.kind == ST_SLV_STAT) check(resp_out.psr_nzlf, e.psr_nzlf);
            end
        end
    end

    initial begin
        logic [3:0] k;
        logic       w;
        for (int i = 0; i < 256; i++) sh[i] = 8'(i) ^ 8'h5a;
        void'($urandom(2));
        repeat (12) @(posedge core_clk_in);
        srst_in <= 1'b0;
        @(posedge core_clk_in);
        // every request code but slave status, odd start and back to back
        for (int i = 0; i < 5; i++)
            op(kinds[i], kinds[i] == ST_SLV_ID, 24'h120001 + 24'(2 * i),
               (kinds[i] == ST_SLV_ID) ? 3'h1 : 3'(2 + i % 3), 32'hc3a51e27);
        idle();
        queue_purge_in <= 1'b1;
        @(posedge core_clk_in);
        queue_purge_in <= 1'b0;
        queue_full_in <= 1'b0;
        wait_ads();
        check(st, ST_FETCH_NSEQ);
        wait_ads();
        check(st, ST_FETCH_SEQ);
        @(posedge core_clk_in);
        queue_full_in <= 1'b1;
        repeat (12) @(posedge core_clk_in);
        op(ST_DATA, 1'b1, 24'h000030, 3'h1, 32'h000000e5);
        idle();
        issue(ST_SLV_STAT, 1'b0, 24'h000030, 3'h1, 32'h0);
        repeat (3) @(negedge core_clk_in);
        repeat (8) begin
            @(negedge core_clk_in);
            check({req_ready_out, st}, {1'b0, ST_SLV_WAIT});
        end
        @(posedge core_clk_in);
        done <= 1'b1;
        take();
        op(ST_SLV_STAT, 1'b0, 24'h000060, 3'h2, 32'h0);
        idle();
        for (int i = 0; i < 60; i++) begin
            if (i % 20 == 0) slow <= ~slow;
            k = kinds[$urandom_range(4)];
            w = (k == ST_SLV_ID) || ((k == ST_DATA || k == ST_SLV_OP) && $urandom_range(1));
            op(k, w, 24'($urandom), (k == ST_SLV_ID) ? 3'h1 : 3'($urandom_range(4, 1)),
               $urandom);
        end
        idle();
        summarize();
    end
endmodule // cpu_bus_status_byte_lanes_tb
`default_nettype wire
